// *** logic/pac_ctrl.sv ***
// camera controller end: strobes a conversion and programs settings
// assumes a plain software register port on CLK_I
`timescale 1ns/1ps
module pac_ctrl (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // link
    pac_link_if.ctrl LINK,
    // software port
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O
);
    // 0x00 go(bit0)/compand(bit1); 0x01..0x03 thresholds; 0x04 end range;
    // 0x10+n writes sensor config register n; 0x01-0x04 read back, 0x00 reads back compand only (go reads 0), 0x08 reads done flag
    logic sample_r;
    logic cfg_we_r;
    logic [7:0] cfg_addr_r;
    logic [7:0] cfg_data_r;
    logic compand_r;
    logic [12:0] th_r [3];
    logic [12:0] eor_r;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sample_r <= 1'b0;
            cfg_we_r <= 1'b0;
            cfg_addr_r <= 8'h00;
            cfg_data_r <= 8'h00;
            compand_r <= 1'b0;
            th_r[0] <= 13'h0000;
            th_r[1] <= 13'h0000;
            th_r[2] <= 13'h0000;
            eor_r <= 13'h0080;
            RDATA_O <= 16'h0000;
        end else begin
            cfg_we_r <= 1'b0;
            sample_r <= 1'b0;
            if (WR_I) begin
                case (ADDR_I)
                    8'h00: begin
                        // only strobe while the last conversion is over
                        sample_r <= WDATA_I[0] && LINK.end_adc;
                        compand_r <= WDATA_I[1];
                    end
                    8'h01: th_r[0] <= WDATA_I[12:0];
                    8'h02: th_r[1] <= WDATA_I[12:0];
                    8'h03: th_r[2] <= WDATA_I[12:0];
                    8'h04: eor_r <= WDATA_I[12:0];
                    default: begin
                        if (ADDR_I[7:4] == 4'h1) begin
                            cfg_we_r <= 1'b1;
                            cfg_addr_r <= {4'h0, ADDR_I[3:0]};
                            cfg_data_r <= WDATA_I[7:0];
                        end
                    end
                endcase
            end
            RDATA_O <= 16'h0000;
            if (RD_I) begin
                case (ADDR_I)
                    8'h00: RDATA_O <= {14'h0000, compand_r, 1'b0};
                    8'h01: RDATA_O <= {3'h0, th_r[0]};
                    8'h02: RDATA_O <= {3'h0, th_r[1]};
                    8'h03: RDATA_O <= {3'h0, th_r[2]};
                    8'h04: RDATA_O <= {3'h0, eor_r};
                    8'h08: RDATA_O <= {15'h0000, LINK.end_adc};
                    default: RDATA_O <= 16'h0000;
                endcase
            end
        end
    end

    assign LINK.sample = sample_r;
    assign LINK.cfg_we = cfg_we_r;
    assign LINK.cfg_addr = cfg_addr_r;
    assign LINK.cfg_data = cfg_data_r;
    assign LINK.compand = compand_r;
    assign LINK.th_one = th_r[0];
    assign LINK.th_two = th_r[1];
    assign LINK.th_three = th_r[2];
    assign LINK.end_range = eor_r;
endmodule : pac_ctrl

// *** logic/pac_link_if.sv ***
// carrier between camera controller and sensor conversion control
// assumes both ends share CLK_I
`timescale 1ns/1ps
interface pac_link_if;
    logic sample;
    logic end_adc;
    logic cfg_we;
    logic [7:0] cfg_addr;
    logic [7:0] cfg_data;
    logic [12:0] end_range;
    logic [12:0] th_one;
    logic [12:0] th_two;
    logic [12:0] th_three;
    logic compand;
    modport device (input sample, cfg_we, cfg_addr, cfg_data, end_range, th_one, th_two, th_three, compand,
        output end_adc);
    modport ctrl (output sample, cfg_we, cfg_addr, cfg_data, end_range, th_one, th_two, th_three, compand,
        input end_adc);
endinterface : pac_link_if

// *** logic/pac_pkg.sv ***
// pixel converter control package: shared constants, types and config fields
// assumes one 40 MHz clock, synchronous active-high reset, no bus in between
package pac_pkg;
    localparam logic [7:0] ADDR_CTRL1 = 8'h01;
    localparam logic [7:0] ADDR_CTRL2 = 8'h02;
    localparam logic [7:0] ADDR_CTRL5 = 8'h05;
    localparam int BIT_ANTI_CORONA = 7;
    localparam int BIT_SATURATE = 5;
    localparam int BIT_DITHER = 3;
    localparam int BIT_DIV_LO = 1;
    localparam int BIT_CDS_GAIN = 5;
    localparam int BIT_ANTI_BLOOM = 3;
    localparam int BIT_ADAPT_BIAS = 1;
    localparam int BIT_RELIN = 1;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h02;
    localparam logic [7:0] CTRL5_RESET = 8'h00;
    localparam int CLOCKS_PER_CODE = 32;
    localparam logic [3:0] DONE_FALL_DELAY = 4'h6;
    localparam logic [3:0] DONE_RISE_EXTRA = 4'h5;
    localparam logic [12:0] SAT_MAX = 13'h0fff;
    localparam int CODE_W = 13;
    localparam int TIME_W = 24;
    localparam logic [31:0] READOUT_MAX_HZ = 32'd50000000;
    localparam logic [31:0] MCLK_HZ = 32'd40000000;
    localparam int DARK_FIRST = 16;
    localparam int DARK_LAST = 20;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LEAD = 3'b010,
        ST_CONV = 3'b100
    } pac_state_type;

    // conversion cycles for one line, in main clocks
    function automatic logic [23:0] conv_cycles(input logic compand, input logic [12:0] eor,
        input logic [12:0] th1, input logic [12:0] th2, input logic [12:0] th3);
        logic [15:0] codes;
        codes = 16'h0000;
        if (compand) begin
            codes = {3'h0, th1} + {4'h0, th2[12:1] - th1[12:1]} + {5'h0, th3[12:2] - th2[12:2]}
                + {6'h0, eor[12:3] - th3[12:3]};
        end else begin
            codes = {3'h0, eor};
        end
        conv_cycles = {3'h0, codes, 5'h00};
    endfunction : conv_cycles
endpackage : pac_pkg

// *** logic/pac_sensor.sv ***
// sensor end: conversion cycle timing, mode latch and configuration bits
// assumes controller drives link synchronously to CLK_I
`timescale 1ns/1ps
module pac_sensor (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // link
    pac_link_if.device LINK,
    // raw ramp code from the pixel comparators
    input wire logic [12:0] RAW_CODE_I,
    input wire logic RAW_VALID_I,
    // analogue controls
    output logic ANTI_BLOOM_O,
    output logic ANTI_CORONA_O,
    output logic CDS_GAIN4_O,
    output logic ADAPT_BIAS_O,
    output logic [1:0] CLK_DIV_O,
    // status and result
    output logic CONVERTING_O,
    output logic [12:0] PIX_O,
    output logic PIX_VALID_O
);
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [7:0] ctrl5_r;
    pac_pkg::pac_state_type state_r;
    logic sample_d_r;
    logic [3:0] lead_r;
    logic [23:0] remain_r;
    logic compand_r;
    logic [12:0] th1_r;
    logic [12:0] th2_r;
    logic [12:0] th3_r;
    logic [12:0] eor_r;
    logic end_adc_r;
    logic dith_r;
    logic [12:0] lin;
    logic [12:0] out_code;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl1_r <= pac_pkg::CTRL1_RESET;
            ctrl2_r <= pac_pkg::CTRL2_RESET;
            ctrl5_r <= pac_pkg::CTRL5_RESET;
        end else if (LINK.cfg_we) begin
            case (LINK.cfg_addr)
                pac_pkg::ADDR_CTRL1: ctrl1_r <= LINK.cfg_data;
                pac_pkg::ADDR_CTRL2: ctrl2_r <= LINK.cfg_data;
                pac_pkg::ADDR_CTRL5: ctrl5_r <= LINK.cfg_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ANTI_BLOOM_O <= 1'b0;
            ANTI_CORONA_O <= 1'b0;
            CDS_GAIN4_O <= 1'b0;
            ADAPT_BIAS_O <= 1'b0;
            CLK_DIV_O <= 2'h0;
        end else begin
            ANTI_BLOOM_O <= ctrl2_r[pac_pkg::BIT_ANTI_BLOOM];
            ANTI_CORONA_O <= ctrl1_r[pac_pkg::BIT_ANTI_CORONA];
            CDS_GAIN4_O <= ctrl2_r[pac_pkg::BIT_CDS_GAIN];
            ADAPT_BIAS_O <= ctrl2_r[pac_pkg::BIT_ADAPT_BIAS];
            CLK_DIV_O <= ctrl1_r[pac_pkg::BIT_DIV_LO +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe taken only in idle; integration and readout live outside
    // this block, so they are free to overlap the conversion
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sample_d_r <= 1'b0;
            state_r <= pac_pkg::ST_IDLE;
            lead_r <= 4'h0;
            remain_r <= 24'h000000;
            end_adc_r <= 1'b1;
            compand_r <= 1'b0;
            th1_r <= 13'h0000;
            th2_r <= 13'h0000;
            th3_r <= 13'h0000;
            eor_r <= 13'h0000;
        end else begin
            sample_d_r <= LINK.sample;
            case (state_r)
                pac_pkg::ST_IDLE: begin
                    if (sample_d_r && !LINK.sample) begin
                        compand_r <= LINK.compand;
                        th1_r <= LINK.th_one;
                        th2_r <= LINK.th_two;
                        th3_r <= LINK.th_three;
                        eor_r <= LINK.end_range;
                        // fall edge is seen one clock late, so five more
                        lead_r <= pac_pkg::DONE_FALL_DELAY - 4'h2;
                        state_r <= pac_pkg::ST_LEAD;
                    end
                end
                pac_pkg::ST_LEAD: begin
                    if (lead_r == 4'h0) begin
                        end_adc_r <= 1'b0;
                        // low for ct+5 clocks; the cycle after this edge is the first of them
                        remain_r <= pac_pkg::conv_cycles(compand_r, eor_r, th1_r, th2_r, th3_r)
                            + {20'h00000, pac_pkg::DONE_RISE_EXTRA} - 24'h000001;
                        state_r <= pac_pkg::ST_CONV;
                    end else begin
                        lead_r <= lead_r - 4'h1;
                    end
                end
                pac_pkg::ST_CONV: begin
                    if (remain_r[23] || remain_r == 24'h000000) begin
                        end_adc_r <= 1'b1;
                        state_r <= pac_pkg::ST_IDLE;
                    end else begin
                        remain_r <= remain_r - 24'h000001;
                    end
                end
                default: state_r <= pac_pkg::ST_IDLE;
            endcase
        end
    end

    assign LINK.end_adc = end_adc_r;

    ////////////////////////////////////////////////////////////////////////
    // undo the companding by doubling every step above th1, dither fills codes between steps
    always_comb begin
        lin = RAW_CODE_I;
        if (compand_r && ctrl5_r[pac_pkg::BIT_RELIN] && RAW_CODE_I > th1_r) begin
            lin = 13'(RAW_CODE_I + (RAW_CODE_I - th1_r));
            if (ctrl1_r[pac_pkg::BIT_DITHER]) begin
                lin = 13'(lin + {12'h000, dith_r});
            end
        end
        out_code = lin;
        if (ctrl1_r[pac_pkg::BIT_SATURATE] && lin > pac_pkg::SAT_MAX) begin
            out_code = pac_pkg::SAT_MAX;
        end else if (!ctrl1_r[pac_pkg::BIT_SATURATE]) begin
            out_code = {1'b0, lin[11:0]};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dith_r <= 1'b0;
            PIX_O <= 13'h0000;
            PIX_VALID_O <= 1'b0;
            CONVERTING_O <= 1'b0;
        end else begin
            dith_r <= RAW_VALID_I ? ~dith_r : dith_r;
            PIX_VALID_O <= RAW_VALID_I;
            if (RAW_VALID_I) begin
                PIX_O <= out_code;
            end
            CONVERTING_O <= !end_adc_r;
        end
    end
endmodule : pac_sensor

// *** verif/pac_link_chk.sv ***
// checker on the link: strobe to done-flag timing
// assumes link is sampled on CLK_I with sync high RST_I
`timescale 1ns/1ps
module pac_link_chk (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // link
    input wire logic sample,
    input wire logic end_adc,
    input wire logic compand,
    input wire logic [12:0] end_range,
    input wire logic [12:0] th_one,
    input wire logic [12:0] th_two,
    input wire logic [12:0] th_three
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [23:0] cnt_r;
    logic [23:0] exp_r;
    logic mode_r;
    logic [15:0] codes;
    ////////////////////////////////////////
    // weights floor each term, as the halving logic does
    assign codes = compand ? 16'(th_one) + 16'((th_two >> 1) - (th_one >> 1)) + 16'((th_three >> 2) - (th_two >> 2))
        + 16'((end_range >> 3) - (th_three >> 3)) : 16'(end_range);
    always_ff @(posedge CLK_I) begin
        if (RST_I || end_adc) begin
            cnt_r <= 24'h000000;
        end else begin
            cnt_r <= cnt_r + 24'h000001;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            exp_r <= 24'h000000;
            mode_r <= 1'b0;
        end else if ($fell(sample) && end_adc) begin
            exp_r <= {3'h0, codes, 5'h00} + 24'h000005;
            mode_r <= compand;
        end
    end
    ////////////////////////////////////////
    AST_FALL_SIX: assert property ($fell(sample) && end_adc |-> end_adc [*6] ##1 !end_adc)
        else $error("done flag did not fall six clocks after strobe");
    AST_FALL_CAUSE: assert property ($fell(end_adc) |-> $past(sample, 7) && !$past(sample, 6))
        else $error("done flag fell without a strobe fall");
    AST_LOW_BOUND: assert property (!end_adc |-> cnt_r < exp_r)
        else $error("done flag low too long");
    AST_RISE_LIN: assert property ($rose(end_adc) && !mode_r |-> cnt_r == exp_r)
        else $error("linear conversion length wrong");
    AST_RISE_CMP: assert property ($rose(end_adc) && mode_r |-> cnt_r == exp_r)
        else $error("companding conversion length wrong");
    AST_PULSE: assert property ($rose(sample) |=> !sample)
        else $error("strobe longer than one clock");
    AST_SAMPLE_IDLE: assert property (sample |-> end_adc)
        else $error("strobe during conversion");
    AST_RESET_IDLE: assert property ($fell(RST_I) |-> end_adc)
        else $error("done flag low after reset");
    cover property ($rose(end_adc) && mode_r);
    cover property ($rose(end_adc) && !mode_r);
    cover property ($fell(sample));
endmodule : pac_link_chk

// *** verif/pixel_adc_conversion_control_test.sv ***
// testbench: controller and sensor joined by the link
// assumes the status bit 0 at 0x08 mirrors the done flag
`timescale 1ns/1ps
module pixel_adc_conversion_control_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [12:0] raw = 13'h0000;
    logic raw_v = 1'b0;
    logic [15:0] rdata;
    logic [12:0] pix;
    logic [1:0] cdiv;
    logic bloom, corona, gain4, bias, conv, pix_v;
    logic [15:0] v;
    logic dith = 1'b0;
    logic [15:0] rq[$];
    logic [12:0] pq[$];
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 63;
    pac_link_if link ();
    pac_ctrl pac_ctrl_i (.CLK_I(clk), .RST_I(rst), .LINK(link), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata));
    pac_sensor pac_sensor_i (.CLK_I(clk), .RST_I(rst), .LINK(link), .RAW_CODE_I(raw), .RAW_VALID_I(raw_v),
        .ANTI_BLOOM_O(bloom), .ANTI_CORONA_O(corona), .CDS_GAIN4_O(gain4), .ADAPT_BIAS_O(bias),
        .CLK_DIV_O(cdiv), .CONVERTING_O(conv), .PIX_O(pix), .PIX_VALID_O(pix_v));
    pac_link_chk pac_link_chk_i (.CLK_I(clk), .RST_I(rst), .sample(link.sample), .end_adc(link.end_adc),
        .compand(link.compand), .end_range(link.end_range), .th_one(link.th_one), .th_two(link.th_two),
        .th_three(link.th_three));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    // expected analogue control pins from the two config bytes
    function automatic logic [15:0] cfg_exp(input logic [7:0] c1, input logic [7:0] c2);
        cfg_exp = {10'h000, c1[2:1], c1[7], c2[5], c2[3], c2[1]};
    endfunction : cfg_exp
    task automatic cfg_chk(input logic [7:0] c1, input logic [7:0] c2);
        repeat (6) @(posedge clk);
        #1;
        cmp({10'h000, cdiv, corona, gain4, bloom, bias}, cfg_exp(c1, c2));
    endtask : cfg_chk
    // mode register is flipped mid-run; the running conversion must not notice
    task automatic conv_run(input logic cmpd, input logic [15:0] e);
        wr_reg(8'h04, e);
        wr_reg(8'h00, {14'h0000, cmpd, 1'b1});
        repeat (10) @(posedge clk);
        cmp({15'h0000, conv}, 16'h0001);
        rd_reg(8'h08, 16'h0000);
        wr_reg(8'h00, {14'h0000, ~cmpd, 1'b0});
        rd_reg(8'h00, {14'h0000, ~cmpd, 1'b0});
        for (int k = 0; k < 2000 && link.end_adc !== 1'b1; k++) @(posedge clk);
        cmp({15'h0000, link.end_adc}, 16'h0001);
        @(posedge clk);
        cmp({15'h0000, conv}, 16'h0000);
    endtask : conv_run
    // relies on the compand run having latched th1 = 0x008 in the sensor
    task automatic px_run(input logic sat, input logic relin);
        logic [12:0] r;
        logic [12:0] l;
        wr_reg(8'h11, {10'h000, sat, 1'b0, relin, 3'h0});
        wr_reg(8'h15, {14'h0000, relin, 1'b0});
        for (int k = 0; k < 8; k++) begin
            r = k == 0 ? 13'h0fff : k == 1 ? 13'h1000 : 13'($random(seed));
            // above th1 the step doubles; dither adds an lsb that toggles per pixel
            l = (relin && r > 13'h0008) ? 13'(r + (r - 13'h0008) + {12'h000, dith}) : r;
            @(posedge clk);
            raw <= r;
            raw_v <= 1'b1;
            dith = ~dith;
            pq.push_back(sat ? (l > 13'h0fff ? 13'h0fff : l) : {1'b0, l[11:0]});
        end
        @(posedge clk);
        raw_v <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : px_run
    ////////////////////////////////////////
    always @(posedge clk) begin
        rd_d <= rd;
        cycles++;
        if (rd_d) cmp(rdata, rq.size() > 0 ? rq.pop_front() : 16'hxxxx);
        if (pix_v) cmp({3'h0, pix}, pq.size() > 0 ? {3'h0, pq.pop_front()} : 16'hxxxx);
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cfg_chk(pac_pkg::CTRL1_RESET, pac_pkg::CTRL2_RESET);
        rd_reg(8'h04, 16'h0080);
        rd_reg(8'h08, 16'h0001);
        rd_reg(8'h3f, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            wr_reg(8'h11, {8'h00, v[7:0]});
            wr_reg(8'h12, {8'h00, v[15:8]});
            cfg_chk(v[7:0], v[15:8]);
        end
        $display("config test done");
        wr_reg(8'h01, 16'h0008);
        wr_reg(8'h02, 16'h0010);
        wr_reg(8'h03, 16'h0018);
        rd_reg(8'h02, 16'h0010);
        conv_run(1'b0, 16'h0002);
        conv_run(1'b1, 16'h0020);
        $display("conversion test done");
        px_run(1'b1, 1'b0);
        px_run(1'b0, 1'b0);
        px_run(1'b1, 1'b1);
        $display("pixel test done");
        stop_test();
    end
endmodule : pixel_adc_conversion_control_test
